// ==== rtl/oxt_pkg.sv ====
// constants shared by the overexcitation inverse-time trip timer
`default_nettype none
package oxt_pkg;
	// clocking and evaluation tick
	localparam int unsigned CLK_PERIOD_NS  = 25;
	localparam int unsigned TICK_PERIOD_NS = 1_000_000;
	localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

	// integrator scale: full scale is the trip threshold
	localparam logic [31:0] FULL_SCALE    = 32'h0100_0000;
	localparam logic [31:0] INHIBIT_LEVEL = 32'h0080_0000;

	// curve selection codes
	localparam logic [1:0] CURVE_ONE   = 2'h0;
	localparam logic [1:0] CURVE_TWO   = 2'h1;
	localparam logic [1:0] CURVE_THREE = 2'h2;
	localparam logic [1:0] CURVE_FOUR  = 2'h3;

	// exponential curves, all terms in milli units
	localparam logic [31:0] CRV_A_PER_TENTH = 32'h0000_00FA;  // 2.5 per unit k = 250 per tenth
	localparam logic [31:0] CRV_B_ONE       = 32'h0001_C138;  // 115.00
	localparam logic [31:0] CRV_B_TWO       = 32'h0001_BB5C;  // 113.50
	localparam logic [31:0] CRV_B_THREE     = 32'h0001_A8CE;  // 108.75
	localparam logic [31:0] CRV_M_SCALE     = 32'h0000_0064;  // 100 times excitation
	// log2(e)/c scaled by 2^24/1000, one per curve (c = 4.886, 3.040, 2.443)
	localparam logic [15:0] CRV_L_ONE       = 16'h135A;
	localparam logic [15:0] CRV_L_TWO       = 16'h1F1A;
	localparam logic [15:0] CRV_L_THREE     = 16'h26B4;
	localparam logic [31:0] CRV_MIN_TO_MS   = 32'h0000_EA60;  // 60 s in ms

	// curve four: 0.18 s per unit k = 18 ms per tenth, times 1e6 for milli-pu squared
	localparam logic [47:0] C4_NUM_PER_TENTH = 48'h0000_0112_A880;
	localparam logic [15:0] PU_ONE_MILLI     = 16'h03E8;

	// percentages and time conversions
	localparam logic [6:0]  PCT_FULL          = 7'h64;
	localparam logic [31:0] RESET_MS_PER_PCTS = 32'h0000_000A;  // 1000 ms / 100 percent
	localparam logic [2:0]  LOW_FREQ_RATIO    = 3'h5;            // 20 percent of nominal
endpackage : oxt_pkg
`default_nettype wire

// ==== rtl/oxt_divider.sv ====
// serial restoring divider, one quotient bit per clock
`default_nettype none
module oxt_divider (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// request
	input  wire logic        start,
	input  wire logic [47:0] num,
	input  wire logic [31:0] den,
	// answer
	output logic             busy,
	output logic             done,
	output logic [47:0]      quot
);
	logic [32:0] rem_reg;
	logic [5:0]  cnt_reg;
	logic [32:0] rem_shift;
	logic        fits;

	assign rem_shift = {rem_reg[31:0], quot[47]};
	// zero divisor always fits, so the quotient saturates to all ones
	assign fits = rem_shift >= {1'b0, den};

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rem_reg <= 33'h0;
			cnt_reg <= 6'h0;
			busy    <= 1'b0;
			done    <= 1'b0;
			quot    <= 48'h0;
		end else begin
			done <= 1'b0;
			if (start) begin
				rem_reg <= 33'h0;
				quot    <= num;
				cnt_reg <= 6'h30;
				busy    <= 1'b1;
			end else if (busy) begin
				rem_reg <= fits ? rem_shift - {1'b0, den} : rem_shift;
				quot    <= {quot[46:0], fits};
				cnt_reg <= cnt_reg - 6'h1;
				if (cnt_reg == 6'h1) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule // oxt_divider
`default_nettype wire

// ==== rtl/oxt_inverse_time_mode_timer.sv ====
// overexcitation inverse-time trip timer with delayed reset and cooling memory
//
// Functional notes
// - pickup and integration begin as soon as excitation exceeds the pickup level
// - higher excitation never yields a longer trip time
// - trip asserts when the integrator passes the curve threshold
// - trip time is clamped between the minimum and maximum trip times
// - dropping below pickup before trip starts the reset timer, state kept
// - returning excitation during reset reuses the retained integration
// - reset time is elapsed percentage at drop over 100 times cooling time
// - integrator decays linearly, reaching zero exactly at reset expiry
// - renewed pickup resumes; elapsed time becomes drop value minus reset elapsed
// - reset expiry without pickup clears stored time and integrator
// - curves one to three: 60 times e to the power (ak+b-100M)/c
// - curve one uses a 2.5, b 115.0, c 4.886
// - curve two uses a 2.5, b 113.50, c 3.040
// - curve three uses a 2.5, b 108.75, c 2.443
// - curve four: constant delay plus 0.18k over (M-1) squared
// - an active trip also asserts the reconnect inhibit output
// - pickup while reconnect inhibit is active trips immediately
// - pickup while only cooling is active integrates on from remaining value
// - frequency below 20 percent of nominal forces excitation to zero
// - percentage output is elapsed pickup time over computed trip time
// - block-all disables the function and resets all timers
`default_nettype none
module oxt_inverse_time_mode_timer #(
	parameter int unsigned TICK_CYC = oxt_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// excitation front end
	input  wire logic [15:0] exc_level_milli,
	input  wire logic [15:0] freq_meas,
	input  wire logic [15:0] freq_nom,
	// settings
	input  wire logic        inverse_time_mode,
	input  wire logic [1:0]  curve_sel,
	input  wire logic [7:0]  pickup_pct,
	input  wire logic [9:0]  time_mult_tenths,
	input  wire logic [16:0] const_delay_ms,
	input  wire logic [31:0] min_trip_ms,
	input  wire logic [31:0] max_trip_ms,
	input  wire logic [13:0] cooling_s,
	input  wire logic        block_all,
	// protection outputs
	output logic             pickup_out,
	output logic             trip_out,
	output logic             reconnect_inhibit_out,
	output logic             cooling_active_out,
	output logic [6:0]       elapsed_fraction_percent
);
	import oxt_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_PICKUP, ST_TRIP, ST_RESET} oxt_state_t;
	typedef enum logic [2:0] {CS_IDLE, CS_C4, CS_TMO, CS_INC, CS_PCT, CS_STEP, CS_APPLY} oxt_calc_t;

	oxt_state_t  st_reg;
	oxt_calc_t   cs_reg;
	logic [15:0] tick_cnt_reg;
	logic        tick;
	logic [15:0] m_lat_reg;
	logic        seq_pick_reg;
	logic [31:0] acc_reg, acc_drop_reg, step_reg, inc_reg;
	logic [31:0] elapsed_reg, elapsed_drop_reg, reset_ms_reg, reset_elapsed_reg;
	logic [31:0] tmo_reg, c4_reg;
	logic [6:0]  pct_reg, pct_q_reg;
	logic        after_trip_reg;
	logic        div_start_reg;
	logic [47:0] div_num_reg;
	logic [31:0] div_den_reg;
	logic        div_busy, div_done;
	logic [47:0] div_quot;

	logic        low_freq, above, apply_pick, apply_reset, expire;
	logic [15:0] m_eff, dm;
	logic [31:0] acc_sum, raw_t, tmo_next, resume_elapsed;

	// lookup of 2^(n/16) in Q14
	function automatic logic [15:0] exp_lut(input logic [3:0] n);
		logic [15:0] v;
		case (n)
			4'h0: v = 16'h4000;  4'h1: v = 16'h42D5;  4'h2: v = 16'h45CB;  4'h3: v = 16'h48E2;
			4'h4: v = 16'h4C1C;  4'h5: v = 16'h4F7B;  4'h6: v = 16'h52FF;  4'h7: v = 16'h56AC;
			4'h8: v = 16'h5A82;  4'h9: v = 16'h5E84;  4'hA: v = 16'h62B4;  4'hB: v = 16'h6712;
			4'hC: v = 16'h6BA2;  4'hD: v = 16'h7066;  4'hE: v = 16'h7560;  default: v = 16'h7A93;
		endcase
		return v;
	endfunction

	function automatic logic [31:0] crv_b(input logic [1:0] sel);
		case (sel)
			CURVE_ONE: return CRV_B_ONE;
			CURVE_TWO: return CRV_B_TWO;
			default:   return CRV_B_THREE;
		endcase
	endfunction

	function automatic logic [15:0] crv_l(input logic [1:0] sel);
		case (sel)
			CURVE_ONE: return CRV_L_ONE;
			CURVE_TWO: return CRV_L_TWO;
			default:   return CRV_L_THREE;
		endcase
	endfunction

	function automatic logic [31:0] clamp_t(input logic [31:0] t, input logic [31:0] lo,
						input logic [31:0] hi);
		if (t < lo) return lo;
		if (t > hi) return hi;
		return t;
	endfunction

	// level detector with low-frequency blanking
	// three extra bits hold five times full scale, so a high reading cannot wrap
	assign low_freq = ({3'b000, freq_meas} * 19'(LOW_FREQ_RATIO)) < {3'b000, freq_nom};
	assign m_eff    = low_freq ? 16'h0 : exc_level_milli;
	assign above    = inverse_time_mode && !block_all
			  && (m_eff > 16'({8'h00, pickup_pct} * 16'h000A));
	assign dm       = (m_eff > PU_ONE_MILLI) ? m_eff - PU_ONE_MILLI : 16'h0;

	// exponential curves evaluated as a power of two
	logic signed [31:0] ex_num, ex_y, ex_int;
	logic signed [47:0] ex_prod;
	logic        [63:0] ex_base, ex_t;
	logic        [5:0]  ex_sh;
	always_comb begin
		ex_num  = $signed({22'h0, time_mult_tenths}) * $signed(CRV_A_PER_TENTH)
			  + $signed(crv_b(curve_sel))
			  - $signed({16'h0, m_lat_reg}) * $signed(CRV_M_SCALE);
		ex_prod = 48'(ex_num) * $signed({32'h0, crv_l(curve_sel)});
		ex_y    = 32'(ex_prod >>> 16);
		ex_int  = ex_y >>> 8;
		ex_base = 64'(CRV_MIN_TO_MS) * 64'(exp_lut(ex_y[7:4]));
		ex_sh   = 6'(-ex_int);
		if (ex_int > 32'sd16) begin
			ex_t = 64'hFFFF_FFFF_FFFF_FFFF;
		end else if (ex_int >= 32'sd0) begin
			ex_t = (ex_base << ex_int[4:0]) >> 14;
		end else if (ex_int < -32'sd40) begin
			ex_t = 64'h0;
		end else begin
			ex_t = ex_base >> (6'd14 + ex_sh);
		end
	end

	// curve four adds the constant delay to the divided term
	always_comb begin
		if (curve_sel == CURVE_FOUR) begin
			raw_t = ({15'h0, const_delay_ms} + c4_reg < c4_reg) ? 32'hFFFF_FFFF
				: {15'h0, const_delay_ms} + c4_reg;
		end else begin
			raw_t = (ex_t[63:32] != 32'h0) ? 32'hFFFF_FFFF : ex_t[31:0];
		end
		tmo_next = clamp_t(raw_t, min_trip_ms, max_trip_ms);
	end

	assign tick           = (tick_cnt_reg == 16'h0);
	assign apply_pick     = (cs_reg == CS_APPLY) && seq_pick_reg;
	assign apply_reset    = (cs_reg == CS_APPLY) && !seq_pick_reg;
	// saturate: a zero trip time gives an all-ones increment that must still trip
	assign acc_sum        = (acc_reg + inc_reg < acc_reg) ? 32'hFFFF_FFFF : acc_reg + inc_reg;
	assign expire         = (reset_elapsed_reg + 32'h1 >= reset_ms_reg);
	assign resume_elapsed = (elapsed_drop_reg > reset_elapsed_reg)
				? elapsed_drop_reg - reset_elapsed_reg : 32'h0;

	// evaluation tick
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tick_cnt_reg <= 16'h0;
		end else begin
			tick_cnt_reg <= tick ? 16'(TICK_CYC - 1) : tick_cnt_reg - 16'h1;
		end
	end

	oxt_divider u_div (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.start   (div_start_reg),
		.num     (div_num_reg),
		.den     (div_den_reg),
		.busy    (div_busy),
		.done    (div_done),
		.quot    (div_quot)
	);

	// per-tick arithmetic sequence shares one serial divider to save area
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cs_reg        <= CS_IDLE;
			div_start_reg <= 1'b0;
			div_num_reg   <= 48'h0;
			div_den_reg   <= 32'h0;
			m_lat_reg     <= 16'h0;
			seq_pick_reg  <= 1'b0;
			c4_reg        <= 32'h0;
			tmo_reg       <= 32'h0;
			inc_reg       <= 32'h0;
			pct_q_reg     <= 7'h0;
			step_reg      <= 32'h0;
		end else begin
			div_start_reg <= 1'b0;
			case (cs_reg)
				CS_IDLE: begin
					if (tick && !block_all && st_reg == ST_PICKUP) begin
						m_lat_reg    <= m_eff;
						seq_pick_reg <= 1'b1;
						if (curve_sel == CURVE_FOUR) begin
							div_num_reg   <= C4_NUM_PER_TENTH * 48'(time_mult_tenths);
							div_den_reg   <= {16'h0, dm} * {16'h0, dm};
							div_start_reg <= 1'b1;
							cs_reg        <= CS_C4;
						end else begin
							cs_reg <= CS_TMO;
						end
					end else if (tick && !block_all && st_reg == ST_RESET) begin
						seq_pick_reg  <= 1'b0;
						div_num_reg   <= {16'h0, acc_drop_reg};
						div_den_reg   <= reset_ms_reg;
						div_start_reg <= 1'b1;
						cs_reg        <= CS_STEP;
					end
				end
				CS_C4: begin
					if (div_done) begin
						c4_reg <= (div_quot[47:32] != 16'h0) ? 32'hFFFF_FFFF : div_quot[31:0];
						cs_reg <= CS_TMO;
					end
				end
				CS_TMO: begin
					tmo_reg       <= tmo_next;
					div_num_reg   <= {16'h0, FULL_SCALE};
					div_den_reg   <= tmo_next;
					div_start_reg <= 1'b1;
					cs_reg        <= CS_INC;
				end
				CS_INC: begin
					if (div_done) begin
						inc_reg       <= div_quot[31:0];
						div_num_reg   <= 48'(elapsed_reg + 32'h1) * 48'(PCT_FULL);
						div_den_reg   <= tmo_reg;
						div_start_reg <= 1'b1;
						cs_reg        <= CS_PCT;
					end
				end
				CS_PCT: begin
					if (div_done) begin
						pct_q_reg <= (div_quot > 48'(PCT_FULL)) ? PCT_FULL : div_quot[6:0];
						cs_reg    <= CS_APPLY;
					end
				end
				CS_STEP: begin
					if (div_done) begin
						step_reg <= div_quot[31:0];
						cs_reg   <= CS_APPLY;
					end
				end
				default: cs_reg <= CS_IDLE;
			endcase
		end
	end

	// protection state, integrator and timers
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg            <= ST_IDLE;
			acc_reg           <= 32'h0;
			acc_drop_reg      <= 32'h0;
			elapsed_reg       <= 32'h0;
			elapsed_drop_reg  <= 32'h0;
			reset_ms_reg      <= 32'h0;
			reset_elapsed_reg <= 32'h0;
			after_trip_reg    <= 1'b0;
			pct_reg           <= 7'h0;
		end else if (block_all || !inverse_time_mode) begin
			st_reg            <= ST_IDLE;
			acc_reg           <= 32'h0;
			elapsed_reg       <= 32'h0;
			reset_elapsed_reg <= 32'h0;
			after_trip_reg    <= 1'b0;
			pct_reg           <= 7'h0;
		end else begin
			case (st_reg)
				ST_IDLE: begin
					if (above) begin
						st_reg      <= ST_PICKUP;
						acc_reg     <= 32'h0;
						elapsed_reg <= 32'h0;
					end
				end
				ST_PICKUP: begin
					if (!above) begin
						st_reg            <= ST_RESET;
						acc_drop_reg      <= acc_reg;
						elapsed_drop_reg  <= elapsed_reg;
						reset_elapsed_reg <= 32'h0;
						reset_ms_reg      <= 32'(pct_reg) * 32'(cooling_s) * RESET_MS_PER_PCTS;
						after_trip_reg    <= 1'b0;
					end else if (apply_pick) begin
						elapsed_reg <= elapsed_reg + 32'h1;
						if (acc_sum >= FULL_SCALE) begin
							st_reg  <= ST_TRIP;
							acc_reg <= acc_sum;
							pct_reg <= PCT_FULL;
						end else begin
							acc_reg <= acc_sum;
							pct_reg <= pct_q_reg;
						end
					end
				end
				ST_TRIP: begin
					if (!above) begin
						st_reg            <= ST_RESET;
						acc_drop_reg      <= acc_reg;
						elapsed_drop_reg  <= elapsed_reg;
						reset_elapsed_reg <= 32'h0;
						reset_ms_reg      <= 32'(pct_reg) * 32'(cooling_s) * RESET_MS_PER_PCTS;
						after_trip_reg    <= 1'b1;
					end
				end
				ST_RESET: begin
					if (above && reconnect_inhibit_out) begin
						st_reg <= ST_TRIP;
					end else if (above) begin
						st_reg         <= ST_PICKUP;
						elapsed_reg    <= resume_elapsed;
						after_trip_reg <= 1'b0;
					end else if (apply_reset) begin
						reset_elapsed_reg <= reset_elapsed_reg + 32'h1;
						if (expire) begin
							st_reg         <= ST_IDLE;
							acc_reg        <= 32'h0;
							elapsed_reg    <= 32'h0;
							after_trip_reg <= 1'b0;
							pct_reg        <= 7'h0;
						end else begin
							acc_reg <= (acc_reg > step_reg) ? acc_reg - step_reg : 32'h0;
						end
					end
				end
				default: st_reg <= ST_IDLE;
			endcase
		end
	end

	// outputs straight from flip-flops, one clock behind the state
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pickup_out               <= 1'b0;
			trip_out                 <= 1'b0;
			reconnect_inhibit_out    <= 1'b0;
			cooling_active_out       <= 1'b0;
			elapsed_fraction_percent <= 7'h0;
		end else begin
			pickup_out <= (st_reg == ST_PICKUP) || (st_reg == ST_TRIP)
				      || (st_reg == ST_RESET && !after_trip_reg);
			trip_out   <= (st_reg == ST_TRIP);
			reconnect_inhibit_out <= (st_reg == ST_TRIP)
				|| (st_reg == ST_RESET && after_trip_reg && acc_reg >= INHIBIT_LEVEL);
			cooling_active_out       <= (st_reg == ST_RESET) && after_trip_reg;
			elapsed_fraction_percent <= pct_reg;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	a_trip_inhibit:   assert property (trip_out |-> reconnect_inhibit_out)
		else $error("trip without reconnect inhibit");
	a_pickup_start:   assert property (st_reg == ST_IDLE && above && inverse_time_mode
		&& !block_all |=> st_reg == ST_PICKUP ##1 pickup_out)
		else $error("pickup not taken at once");
	a_trip_restrike:  assert property (st_reg == ST_RESET && above && reconnect_inhibit_out
		|=> st_reg == ST_TRIP ##1 trip_out)
		else $error("no immediate trip under inhibit");
	a_cool_resume:    assert property (st_reg == ST_RESET && above && !reconnect_inhibit_out
		|=> st_reg == ST_PICKUP && acc_reg == $past(acc_reg) && !trip_out)
		else $error("cooling pickup lost its integrator");
	a_resume_elapsed: assert property (st_reg == ST_RESET && above && !reconnect_inhibit_out
		|=> elapsed_reg == $past(resume_elapsed))
		else $error("resumed elapsed time wrong");
	a_clamp_range:    assert property (cs_reg == CS_INC && min_trip_ms <= max_trip_ms
		|-> tmo_reg >= min_trip_ms && tmo_reg <= max_trip_ms)
		else $error("trip time outside limits");
	a_block_clear:    assert property (block_all |=> st_reg == ST_IDLE && acc_reg == 32'h0
		##1 !pickup_out && !trip_out)
		else $error("block did not clear the function");
	a_low_freq:       assert property (low_freq |-> !above)
		else $error("pickup allowed at low frequency");
	a_trip_full:      assert property (apply_pick && st_reg == ST_PICKUP && above
		&& acc_sum >= FULL_SCALE |=> st_reg == ST_TRIP ##1 trip_out)
		else $error("full integrator did not trip");
	a_reset_expiry:   assert property (apply_reset && st_reg == ST_RESET && !above && expire
		|=> acc_reg == 32'h0 && elapsed_reg == 32'h0 ##1 !pickup_out)
		else $error("expiry left stored state");
	a_pct_bound:      assert property (elapsed_fraction_percent <= PCT_FULL)
		else $error("percentage above full");
	a_div_idle:       assert property (div_start_reg |-> !div_busy)
		else $error("divider restarted while busy");

	c_trip:     cover property (st_reg == ST_PICKUP ##1 st_reg == ST_TRIP);
	c_restrike: cover property (st_reg == ST_RESET && reconnect_inhibit_out ##1 st_reg == ST_TRIP);
	c_cooling:  cover property (cooling_active_out && !reconnect_inhibit_out && above);
	c_expiry:   cover property (st_reg == ST_RESET ##1 st_reg == ST_IDLE);
endmodule // oxt_inverse_time_mode_timer
`default_nettype wire

// ==== testbench/oxt_front_model.sv ====
// behavioural excitation front end feeding the trip timer
`default_nettype none
module oxt_front_model (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// requests from the bench
	input  wire logic [15:0] level_req,
	input  wire logic [15:0] nom_req,
	input  wire logic        low_freq,
	// towards the timer
	output var logic  [15:0] exc_level_milli,
	output var logic  [15:0] freq_meas,
	output var logic  [15:0] freq_nom
);
	timeunit 1ns;
	timeprecision 1ps;
	// registered, like a real measurement chain that updates once a sample
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			exc_level_milli <= 16'h0000;
			freq_meas       <= 16'h0000;
			freq_nom        <= 16'h0000;
		end else begin
			exc_level_milli <= level_req;
			freq_nom        <= nom_req;
			// an eighth of nominal sits well under the low-frequency limit
			freq_meas       <= low_freq ? (nom_req >> 3) : nom_req;
		end
	end
endmodule // oxt_front_model
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench for the inverse-time trip timer
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import oxt_pkg::*;
	localparam int TC = 220;
	typedef struct {int start; int exp; int tol;} oxt_note_t;
	logic        ref_clk, sys_rst, mode, blk, low_f, trip_q;
	logic [15:0] lvl, nom, exc, fm, fn;
	logic [1:0]  crv;
	logic [7:0]  pu_pct;
	logic [9:0]  kt;
	logic [16:0] dly;
	logic [31:0] mn, mx;
	logic [13:0] cool;
	logic        pu, tr, inh, cl;
	logic [6:0]  pct;
	int          fail_count, check_count, cyc, meas, seed, e;
	oxt_note_t   notes[$];
	oxt_note_t   nt;

	oxt_front_model fe (.ref_clk(ref_clk), .sys_rst(sys_rst), .level_req(lvl), .nom_req(nom),
		.low_freq(low_f), .exc_level_milli(exc), .freq_meas(fm), .freq_nom(fn));
	oxt_inverse_time_mode_timer #(.TICK_CYC(TC)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.exc_level_milli(exc), .freq_meas(fm), .freq_nom(fn), .inverse_time_mode(mode),
		.curve_sel(crv), .pickup_pct(pu_pct), .time_mult_tenths(kt), .const_delay_ms(dly),
		.min_trip_ms(mn), .max_trip_ms(mx), .cooling_s(cool), .block_all(blk),
		.pickup_out(pu), .trip_out(tr), .reconnect_inhibit_out(inh),
		.cooling_active_out(cl), .elapsed_fraction_percent(pct));

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		check_count++;
		if (got !== ex) begin
			fail_count++;
			$display("[ERR] %s expected %0h seen %0h", nm, ex, got);
		end
	endtask

	task automatic ticks(input int n);
		repeat (n * TC) @(posedge ref_clk);
	endtask

	// expected trip time in ticks, one tick later since full scale needs one extra add
	function automatic int exp_ms(input int c, input int m);
		real t;
		real b[3] = '{115.0, 113.5, 108.75};
		real cc[3] = '{4.886, 3.040, 2.443};
		if (c == 3) t = dly + 18.0 * kt * 1.0e6 / ((m - 1000.0) * (m - 1000.0));
		else t = 60000.0 * $exp((0.25 * kt + b[c] - m / 10.0) / cc[c]);
		if (t < mn) t = mn;
		if (t > mx) t = mx;
		return int'(t) + 1;
	endfunction

	// note the expected delay, then raise the level on the same edge
	task automatic raise(input logic [15:0] m, input int ex, input int tol);
		@(posedge ref_clk);
		lvl <= m;
		notes.push_back('{cyc, ex, tol});
	endtask

	task automatic set_lvl(input logic [15:0] m);
		@(posedge ref_clk);
		lvl <= m;
	endtask

	task automatic wait_trip(input int lim);
		int n;
		n = 0;
		while (tr !== 1'b1 && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		@(negedge ref_clk);
		chk("trip_out", 1, tr);
	endtask

	task automatic clear;
		@(posedge ref_clk);
		blk <= 1'b1;
		lvl <= 16'h0000;
		nom <= 16'h0100 + 16'($random(seed) & 32'h0FFF);
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("pickup_out", 0, pu);
		chk("trip_out", 0, tr);
		@(posedge ref_clk);
		blk <= 1'b0;
	endtask

	task automatic run_trip(input logic [1:0] c, input int m, input int lo, input int hi);
		clear();
		crv <= c;
		mn <= lo;
		mx <= hi;
		@(negedge ref_clk);
		e = exp_ms(c, m);
		raise(m, e, 2 + e / 20);
		repeat (4) @(negedge ref_clk);
		chk("pickup_out", 1, pu);
		wait_trip((e + 20) * TC);
		@(negedge ref_clk);
		chk("reconnect_inhibit_out", 1, inh);
		chk("elapsed_fraction_percent", PCT_FULL, pct);
	endtask

	// result watcher: each trip edge consumes the oldest note
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		trip_q <= tr;
		if (tr === 1'b1 && trip_q === 1'b0) begin
			if (notes.size() == 0) begin
				fail_count++;
				$display("[ERR] trip_out expected 0 seen 1");
			end else begin
				nt = notes.pop_front();
				meas = (cyc - nt.start) / TC;
				check_count++;
				if (meas < nt.exp - nt.tol || meas > nt.exp + nt.tol) begin
					fail_count++;
					$display("[ERR] trip delay ticks expected %0d seen %0d", nt.exp, meas);
				end
			end
		end
	end

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (90000) @(posedge ref_clk);
		fail_count++;
		wrap_up();
	end

	initial begin
		seed = 32'h99e5;
		{fail_count, check_count, cyc} = '0;
		trip_q = 1'b0;
		sys_rst = 1'b1;
		{mode, blk, low_f, crv, kt, dly, cool} = '0;
		lvl = 16'h0000;
		nom = 16'h0320;
		pu_pct = 8'h6E;
		mn = 32'h0000_0001;
		mx = 32'h0001_86A0;
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(negedge ref_clk);
		chk("outputs after reset", 0, {pu, tr, inh, cl, pct});
		@(posedge ref_clk);
		mode <= 1'b1;
		kt <= 10'h001;
		dly <= 17'h00014;
		cool <= 14'h0001;
		low_f <= 1'b1;
		lvl <= 16'h07D0;
		ticks(2);
		@(negedge ref_clk);
		chk("pickup_out low frequency", 0, pu);
		@(posedge ref_clk);
		low_f <= 1'b0;
		// one trip per curve near 30 ms for curves one to three, then curve four twice, clamped to 40 and 45 ms
		run_trip(CURVE_ONE, 1524, 1, 100000);
		run_trip(CURVE_TWO, 1369, 1, 100000);
		run_trip(CURVE_THREE, 1276, 1, 100000);
		run_trip(CURVE_FOUR, 3000, 40, 100000);
		run_trip(CURVE_FOUR, 1500, 1, 45);
		// drop after trip, come back while inhibit holds: no integration
		set_lvl(16'h0000);
		repeat (5) @(negedge ref_clk);
		chk("cooling_active_out", 1, cl);
		raise(16'h07D0, 0, 1);
		wait_trip(4);
		// short drop before trip keeps the integration
		clear();
		mn <= 32'h0000_0001;
		mx <= 32'h0001_86A0;
		@(negedge ref_clk);
		e = exp_ms(3, 2000);
		set_lvl(16'h07D0);
		ticks(10);
		set_lvl(16'h0000);
		ticks(5);
		@(negedge ref_clk);
		chk("pickup_out during reset", 1, pu);
		raise(16'h07D0, e - 10, 4);
		wait_trip((e + 10) * TC);
		// short pickup then full reset expiry
		clear();
		set_lvl(16'h07D0);
		ticks(3);
		set_lvl(16'h0000);
		ticks(40);
		@(negedge ref_clk);
		chk("pickup_out during reset", 1, pu);
		for (int n = 0; n < 100 * TC && pu === 1'b1; n++) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("pickup_out after reset", 0, pu);
		chk("elapsed_fraction_percent", 0, pct);
		wrap_up();
	end
endmodule // tb
`default_nettype wire
